// file: design/spp_port.sv
// Serial programming port with shadow registers, lock and OTP commit
`timescale 1ns/1ns
`default_nettype none

// Function
// - Select low makes pins the programming port
// - Select high: port ignores pin activity
// - Read returns eight data bits on output
// - Output bit changes after each falling edge
// - Key 0xAB at 0x10 unlocks protected registers
// - Some addresses are always writable
// - Key 0xA1 at 0x11 burns bytes 0-1
// - Key 0xA2 at 0x12 burns bytes 2-3
// - Key 0xA3 at 0x13 burns bytes 4-6
module spp_port
    import spp_pkg::*;
(
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              reset_n,
    // Shared pins
    input  wire logic                              protocol_select_pin,
    input  wire logic                              shared_serial_clock_pin,
    input  wire logic                              shared_frame_or_datain_pin,
    output logic                                   shared_dataout_pin,
    output logic                                   dataoutEnable,
    // Lock and nonvolatile state
    output logic                                   regsUnlocked,
    output logic      [OTP_GROUPS-1:0]             otpCommitPulse,
    output logic      [OTP_GROUPS-1:0]             otpBurned,
    output logic      [OTP_BYTES-1:0][DATA_W-1:0]  otpImage
);

    logic [SYNC_W-1:0]     pinSync;
    logic                  progMode;
    logic                  sclk;
    logic                  din;
    logic                  sclkPrev_q;
    logic                  sclkRise;
    logic                  sclkFall;
    spp_state_t            state_q;
    logic [CNT_W-1:0]      bitCnt_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic [FRAME_BITS-1:0] shiftNext;
    logic [DATA_W-1:0]     readBuf_q;
    spp_wr_t               wr_q;
    logic [DATA_W-1:0]     regs_q [REG_COUNT];
    logic                  addrOpen;
    logic                  wrAllowed;
    logic [OTP_GROUPS-1:0] commitHit;

    // Pin synchronisation
    spp_sync u_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .asyncIn ({shared_frame_or_datain_pin, shared_serial_clock_pin, protocol_select_pin}),
        .syncOut (pinSync)
    );

    assign progMode  = ~pinSync[SYNC_SEL];
    assign sclk      = pinSync[SYNC_CLK];
    assign din       = pinSync[SYNC_DIN];
    assign sclkRise  = progMode & sclk & ~sclkPrev_q;
    assign sclkFall  = progMode & ~sclk & sclkPrev_q;
    assign shiftNext = {shift_q[FRAME_BITS-2:0], din};

    // Clock edge detection
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclkPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= sclk;
        end
    end

    // Frame sequencing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= ST_CMD;
            bitCnt_q  <= CNT_ZERO;
            shift_q   <= SHIFT_IDLE;
            readBuf_q <= REG_RESET;
        end else if (!progMode) begin
            state_q  <= ST_CMD;
            bitCnt_q <= CNT_ZERO;
        end else if (sclkRise) begin
            shift_q  <= shiftNext;
            bitCnt_q <= bitCnt_q + CNT_ONE;
            case (state_q)
                ST_CMD: begin
                    if (bitCnt_q == CNT_CMD_LAST) begin
                        case (shiftNext[CMD_BITS-1 -: CMD_BITS-ADDR_W])
                            OP_READ: begin
                                state_q   <= ST_READ;
                                readBuf_q <= regs_q[shiftNext[ADDR_W-1:0]];
                            end
                            OP_WRITE: begin
                                state_q <= ST_WRITE;
                            end
                            default: begin
                                state_q <= ST_SKIP;
                            end
                        endcase
                    end
                end
                ST_READ, ST_WRITE, ST_SKIP: begin
                    if (bitCnt_q == CNT_FRM_LAST) begin
                        state_q  <= ST_CMD;
                        bitCnt_q <= CNT_ZERO;
                    end
                end
                default: begin
                    state_q  <= ST_CMD;
                    bitCnt_q <= CNT_ZERO;
                end
            endcase
        end else if (sclkFall && state_q == ST_READ) begin
            readBuf_q <= {readBuf_q[DATA_W-2:0], DOUT_IDLE};
        end
    end

    // Data output, moved on falling clock edges and forced idle while deselected
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shared_dataout_pin <= DOUT_IDLE;
        end else if (!progMode) begin
            shared_dataout_pin <= DOUT_IDLE;
        end else if (sclkFall) begin
            if (state_q == ST_READ) begin
                shared_dataout_pin <= readBuf_q[DATA_W-1];
            end else begin
                shared_dataout_pin <= DOUT_IDLE;
            end
        end
    end

    // Output driver enable follows the mode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataoutEnable <= 1'b0;
        end else begin
            dataoutEnable <= progMode;
        end
    end

    // Write capture at the last bit of a write frame
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
        end else begin
            wr_q.valid <= progMode && sclkRise && state_q == ST_WRITE
                          && bitCnt_q == CNT_FRM_LAST;
            wr_q.addr  <= shiftNext[FRAME_BITS-CMD_BITS+ADDR_W-1 -: ADDR_W];
            wr_q.data  <= shiftNext[DATA_W-1:0];
        end
    end

    // Write protection
    always_comb begin
        addrOpen = (wr_q.addr <= ADDR_OPEN_LAST)
                 || (wr_q.addr == ADDR_UNLOCK)
                 || (wr_q.addr == ADDR_COMMIT_RSVD)
                 || (wr_q.addr == ADDR_COMMIT_ZERO)
                 || (wr_q.addr == ADDR_OPEN_EXTRA);
        wrAllowed = wr_q.valid && (regsUnlocked || addrOpen);
        commitHit[GRP_RSVD] = wrAllowed && wr_q.addr == ADDR_COMMIT_RSVD
                              && wr_q.data == KEY_RSVD;
        commitHit[GRP_ZERO] = wrAllowed && wr_q.addr == ADDR_COMMIT_ZERO
                              && wr_q.data == KEY_ZERO;
        commitHit[GRP_CFG]  = wrAllowed && wr_q.addr == ADDR_COMMIT_CFG
                              && wr_q.data == KEY_CFG;
    end

    // Register array
    generate
        for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    regs_q[i] <= REG_RESET;
                end else if (wrAllowed && wr_q.addr == ADDR_W'(i)) begin
                    regs_q[i] <= wr_q.data;
                end
            end
        end
    endgenerate

    // Lock state, only the exact key opens it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regsUnlocked <= 1'b0;
        end else if (wrAllowed && wr_q.addr == ADDR_UNLOCK && wr_q.data == KEY_UNLOCK) begin
            regsUnlocked <= 1'b1;
        end
    end

    // Commit pulses and one-time burn flags
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            otpCommitPulse <= '0;
            otpBurned      <= '0;
        end else begin
            otpCommitPulse <= commitHit & ~otpBurned;
            otpBurned      <= otpBurned | otpCommitPulse;
        end
    end

    // Nonvolatile image, copied once per group
    generate
        for (genvar b = 0; b < OTP_BYTES; b++) begin : g_otp
            localparam int GRP = (b <= RSVD_HI) ? GRP_RSVD :
                                 (b <= ZERO_HI) ? GRP_ZERO : GRP_CFG;
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    otpImage[b] <= REG_RESET;
                end else if (otpCommitPulse[GRP]) begin
                    otpImage[b] <= regs_q[b];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: design/spp_sync.sv
// Two-stage synchroniser for the shared pin inputs
`timescale 1ns/1ns
`default_nettype none

module spp_sync
    import spp_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Asynchronous inputs and synchronised outputs
    input  wire logic [SYNC_W-1:0] asyncIn,
    output logic      [SYNC_W-1:0] syncOut
);

    logic [SYNC_W-1:0] meta_q;

    // Pins idle high, so both stages reset high
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q  <= '1;
            syncOut <= '1;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: dv/spp_host_model.sv
// Host controller model driving the shared programming pins
`timescale 1ns/1ns
`default_nettype none

module spp_host_model (
    // Clock
    input  wire logic sys_clk,
    // Shared pins
    input  wire logic dout,
    output logic      sel,
    output logic      sclk,
    output logic      din
);
    int halfCyc = 50;

    initial begin
        sel  = 1'b1;
        sclk = 1'b1;
        din  = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Mode switch with clock held high
    task automatic setSel(input logic v);
        wt(100);
        sel = v;
        wt(100);
    endtask

    // One 16-bit frame, MSB first; last eight bits seen returned
    task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            din  = frm[i];
            wt(halfCyc);
            sclk = 1'b1;
            rd   = {rd[6:0], dout};
            wt(halfCyc);
        end
        din = 1'b1;
        wt(halfCyc);
    endtask
endmodule

`default_nettype wire

// file: dv/spp_port_properties.sv
// Concurrent checks on the programming port outputs
`timescale 1ns/1ns
`default_nettype none

module spp_port_properties
    import spp_pkg::*;
(
    // Clock and reset
    input  wire logic                             sys_clk,
    input  wire logic                             reset_n,
    // Shared pins
    input  wire logic                             protocol_select_pin,
    input  wire logic                             shared_serial_clock_pin,
    input  wire logic                             shared_dataout_pin,
    input  wire logic                             dataoutEnable,
    // Lock and nonvolatile state
    input  wire logic                             regsUnlocked,
    input  wire logic [OTP_GROUPS-1:0]            otpCommitPulse,
    input  wire logic [OTP_GROUPS-1:0]            otpBurned,
    input  wire logic [OTP_BYTES-1:0][DATA_W-1:0] otpImage
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_sel_quiet; protocol_select_pin [*4] |-> shared_dataout_pin && !dataoutEnable;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("port active when deselected");
    property p_port_on; !protocol_select_pin [*5] |-> dataoutEnable; endproperty
    a_port_on: assert property (p_port_on) else $error("port not enabled");
    property p_dout_fall;
        $changed(shared_dataout_pin) |->
            !$past(shared_serial_clock_pin, 3) || $past(protocol_select_pin, 2);
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("dout moved off a fall");
    property p_burn_next; otpCommitPulse != '0 |=>
        (otpBurned & $past(otpCommitPulse)) == $past(otpCommitPulse); endproperty
    a_burn_next: assert property (p_burn_next) else $error("burn flag late");
    property p_fresh; (otpCommitPulse & otpBurned) == '0; endproperty
    a_fresh: assert property (p_fresh) else $error("group burned twice");
    property p_cfg_lock; otpCommitPulse[GRP_CFG] |-> regsUnlocked; endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("config commit while locked");
    property p_sticky; (otpBurned & $past(otpBurned)) == $past(otpBurned)
        && (regsUnlocked || !$past(regsUnlocked)); endproperty
    a_sticky: assert property (p_sticky) else $error("sticky state cleared");
    property p_img; otpBurned == $past(otpBurned) |-> $stable(otpImage); endproperty
    a_img: assert property (p_img) else $error("image changed without burn");
endmodule

`default_nettype wire

// file: dv/spp_port_tb.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

module spp_port_tb
    import spp_pkg::*;
;
    logic                             sys_clk = 1'b0;
    logic                             reset_n = 1'b0;
    logic                             sel, sclk, din, dout, oe, unl;
    logic [OTP_GROUPS-1:0]            pulse, burned, burnExp;
    logic [OTP_BYTES-1:0][DATA_W-1:0] image, imgExp;
    logic [DATA_W-1:0]                shadow [REG_COUNT];
    logic                             unlockExp;
    int                               err_count, checks;
    int                               pulseCnt;

    always #5 sys_clk = ~sys_clk;

    // Commit pulses counted where they stand settled
    always @(negedge sys_clk) begin
        pulseCnt += $countones(pulse);
    end

    spp_host_model u_spp_host_model (.sys_clk(sys_clk), .dout(dout), .sel(sel),
        .sclk(sclk), .din(din));
    spp_port u_spp_port (.sys_clk(sys_clk), .reset_n(reset_n), .protocol_select_pin(sel),
        .shared_serial_clock_pin(sclk), .shared_frame_or_datain_pin(din),
        .shared_dataout_pin(dout), .dataoutEnable(oe), .regsUnlocked(unl),
        .otpCommitPulse(pulse), .otpBurned(burned), .otpImage(image));

    function automatic logic canWrite(input logic [ADDR_W-1:0] a);
        return unlockExp || a <= ADDR_OPEN_LAST || a inside {ADDR_UNLOCK, ADDR_COMMIT_RSVD,
            ADDR_COMMIT_ZERO, ADDR_OPEN_EXTRA};
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [7:0] v;
        logic       ok;
        ok = canWrite(a);
        u_spp_host_model.xfer({OP_WRITE, a, d}, v);
        if (ok) shadow[a] = d;
        if (ok && a == ADDR_UNLOCK && d == KEY_UNLOCK) unlockExp = 1'b1;
        for (int g = 0; g < OTP_GROUPS; g++)
            if (ok && a == ADDR_COMMIT_RSVD + 6'(g) && d == KEY_RSVD + 8'(g) && !burnExp[g]) begin
                burnExp[g] = 1'b1;
                for (int b = 2 * g; b <= 2 * g + 1 + int'(g == GRP_CFG); b++)
                    imgExp[b] = shadow[b];
            end
        `CHK(unl, unlockExp)
        `CHK(burned, burnExp)
        `CHK(image, imgExp)
        `CHK(pulseCnt, $countones(burnExp))
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        u_spp_host_model.xfer({OP_READ, a, 8'hff}, v);
        `CHK(v, shadow[a])
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        logic [7:0]        v;
        logic [ADDR_W-1:0] a;
        void'($urandom(10637));
        shadow = '{default: REG_RESET};
        unlockExp = 1'b0;
        burnExp = '0;
        imgExp = '0;
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        u_spp_host_model.setSel(1'b0);
        `CHK(oe, 1'b1)
        for (int i = 16; i < 20; i++) rd(6'(i));
        for (int i = 0; i < 4; i++) wr(6'(i), 8'($urandom));
        for (int i = 0; i < 4; i++) rd(6'(i));
        wr(6'h04, 8'h5a);
        rd(6'h04);
        wr(ADDR_UNLOCK, 8'haa);
        rd(ADDR_UNLOCK);
        $display("test lock done");
        wr(ADDR_COMMIT_ZERO, KEY_CFG);
        wr(ADDR_COMMIT_RSVD, KEY_RSVD);
        wr(ADDR_COMMIT_ZERO, KEY_ZERO);
        wr(ADDR_COMMIT_CFG, KEY_CFG);
        wr(ADDR_UNLOCK, KEY_UNLOCK);
        for (int i = 4; i < 7; i++) wr(6'(i), 8'($urandom));
        wr(ADDR_COMMIT_CFG, KEY_CFG);
        wr(6'h00, 8'h3c);
        wr(ADDR_COMMIT_RSVD, KEY_RSVD);
        $display("test commit done");
        u_spp_host_model.xfer({2'h0, 6'h00, 8'hff}, v);
        `CHK(v, 8'hff)
        u_spp_host_model.xfer({2'h3, 6'h00, 8'h11}, v);
        `CHK(v, 8'hff)
        rd(6'h00);
        u_spp_host_model.setSel(1'b1);
        u_spp_host_model.xfer({OP_WRITE, 6'h01, 8'h77}, v);
        `CHK(v, 8'hff)
        `CHK(oe, 1'b0)
        u_spp_host_model.setSel(1'b0);
        rd(6'h01);
        $display("test modes done");
        for (int i = 0; i < 4; i++) begin
            a = 6'($urandom_range(20, 63));
            wr(a, 8'($urandom));
            rd(a);
        end
        $display("test random done");
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule

bind spp_port spp_port_properties u_spp_port_properties (.sys_clk(sys_clk),
    .reset_n(reset_n), .protocol_select_pin(protocol_select_pin),
    .shared_serial_clock_pin(shared_serial_clock_pin),
    .shared_dataout_pin(shared_dataout_pin), .dataoutEnable(dataoutEnable),
    .regsUnlocked(regsUnlocked), .otpCommitPulse(otpCommitPulse),
    .otpBurned(otpBurned), .otpImage(otpImage));

`default_nettype wire

// file: shared/spp_pkg.sv
// Constants and types for the serial programming port
package spp_pkg;

    // Widths and frame shape
    localparam int ADDR_W     = 6;
    localparam int DATA_W     = 8;
    localparam int REG_COUNT  = 64;
    localparam int CMD_BITS   = 8;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W      = 4;
    localparam int OTP_BYTES  = 7;
    localparam int OTP_GROUPS = 3;

    // Synchroniser lanes
    localparam int SYNC_W   = 3;
    localparam int SYNC_SEL = 0;
    localparam int SYNC_CLK = 1;
    localparam int SYNC_DIN = 2;

    // Command opcodes
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // Bit counter marks
    localparam logic [CNT_W-1:0] CNT_ZERO     = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE      = 4'h1;
    localparam logic [CNT_W-1:0] CNT_CMD_LAST = 4'h7;
    localparam logic [CNT_W-1:0] CNT_FRM_LAST = 4'hf;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_OPEN_LAST   = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK      = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_COMMIT_RSVD = 6'h11;
    localparam logic [ADDR_W-1:0] ADDR_COMMIT_ZERO = 6'h12;
    localparam logic [ADDR_W-1:0] ADDR_COMMIT_CFG  = 6'h13;
    localparam logic [ADDR_W-1:0] ADDR_OPEN_EXTRA  = 6'h1b;

    // Last shadow byte of the first two commit groups
    localparam int RSVD_HI = 1;
    localparam int ZERO_HI = 3;

    // Command codes
    localparam logic [DATA_W-1:0] KEY_UNLOCK = 8'hab;
    localparam logic [DATA_W-1:0] KEY_RSVD   = 8'ha1;
    localparam logic [DATA_W-1:0] KEY_ZERO   = 8'ha2;
    localparam logic [DATA_W-1:0] KEY_CFG    = 8'ha3;

    // Reset and idle values
    localparam logic [DATA_W-1:0]     REG_RESET  = 8'h00;
    localparam logic [FRAME_BITS-1:0] SHIFT_IDLE = 16'h0000;
    localparam logic                  DOUT_IDLE  = 1'b1;

    // Commit group indices
    localparam int GRP_RSVD = 0;
    localparam int GRP_ZERO = 1;
    localparam int GRP_CFG  = 2;

    // One register write taken from the serial frame
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } spp_wr_t;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_READ,
        ST_WRITE,
        ST_SKIP
    } spp_state_t;

endpackage
